// ===== hdl/pscmp_pkg.sv
package pscmp_pkg;

    // Timing
    localparam int unsigned CLK_NS     = 100;
    localparam int unsigned MS_NS      = 1000000;
    localparam int unsigned MS_CYC     = MS_NS / CLK_NS;
    localparam int unsigned PROG_MS    = 5;
    localparam int unsigned DELTA_MS   = 20;
    localparam int unsigned DELTA_TAPS = DELTA_MS / PROG_MS;
    localparam int unsigned LOG_DEPTH  = 12;
    localparam int unsigned HYST_SCALE = 10000;
    localparam int unsigned RATIO_SH   = 8;

    // Register byte offsets
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_MODE      = 8'h04;
    localparam logic [7:0] A_LEVEL     = 8'h08;
    localparam logic [7:0] A_HYST      = 8'h0c;
    localparam logic [7:0] A_BLIM      = 8'h10;
    localparam logic [7:0] A_OP_DLY    = 8'h14;
    localparam logic [7:0] A_REL_DLY   = 8'h18;
    localparam logic [7:0] A_EVT_SEL   = 8'h1c;
    localparam logic [7:0] A_STATUS    = 8'h20;
    localparam logic [7:0] A_CNT_START = 8'h24;
    localparam logic [7:0] A_CNT_TRIP  = 8'h28;
    localparam logic [7:0] A_CNT_BLK   = 8'h2c;
    localparam logic [7:0] A_LOG_SEL   = 8'h30;
    localparam logic [7:0] A_LOG_TIME  = 8'h34;
    localparam logic [7:0] A_LOG_ID    = 8'h38;
    localparam logic [7:0] A_LOG_MAG   = 8'h3c;
    localparam logic [7:0] A_LOG_RATIO = 8'h40;
    localparam logic [7:0] A_LOG_REM   = 8'h44;

    // Field positions
    localparam int unsigned F_BLIM_EN  = 4;
    localparam int unsigned F_GROUP    = 8;

    // Reset values
    localparam logic signed [31:0] LEVEL_RST = 32'sh0000_0001;
    localparam logic [15:0] HYST_RST    = 16'h012c;
    localparam logic [31:0] OP_DLY_RST  = 32'h0000_0028;
    localparam logic [31:0] REL_DLY_RST = 32'h0000_003c;
    localparam logic [5:0]  EVT_SEL_RST = 6'h3f;

    // Record identities
    localparam logic [1:0] ID_START = 2'h1;
    localparam logic [1:0] ID_TRIP  = 2'h2;
    localparam logic [1:0] ID_BLOCK = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        M_OVER, M_OVER_ABS, M_UNDER, M_UNDER_ABS,
        M_DPCT, M_DPCT_ABS, M_DVAL, M_DVAL_ABS
    } pscmp_mode_t;

    typedef enum logic [1:0] {S_IDLE, S_START, S_TRIP, S_BLOCKED} pscmp_state_t;

    typedef struct packed {
        pscmp_mode_t        mode;
        logic               blim_en;
        logic signed [31:0] level;
        logic [15:0]        hyst;
        logic signed [31:0] blim;
    } pscmp_cfg_t;

    typedef struct packed {
        logic [31:0]        stamp;
        logic [1:0]         id;
        logic signed [31:0] mag;
        logic signed [31:0] ratio;
        logic [31:0]        remain;
        logic [2:0]         group;
    } pscmp_rec_t;

    function automatic logic [47:0] f_abs(input logic signed [47:0] x);
        f_abs = (x < 0) ? 48'(-x) : 48'(x);
    endfunction

    // Fraction of x in hundredths of a percent
    function automatic logic [47:0] f_frac(input logic [47:0] x, input logic [31:0] k);
        f_frac = 48'((80'(x) * 80'(k)) / 80'(HYST_SCALE));
    endfunction

    function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                o[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        f_merge = o;
    endfunction

endpackage

// ===== hdl/pscmp_cmp.sv
module pscmp_cmp (
    // Settings and samples
    input  wire pscmp_pkg::pscmp_cfg_t i_cfg,
    input  wire logic signed [31:0]    i_meas,
    input  wire logic signed [31:0]    i_old,
    input  wire logic                  i_active,
    // Result
    output logic                       o_cond
);
    import pscmp_pkg::*;

    logic signed [47:0] meas, old, lvl, d, hys, thr_hi, thr_lo, amag, rel;
    logic [47:0]        alvl, pick;

    // Comparison with hysteresis that widens only once the condition holds
    always_comb begin
        meas   = 48'(i_meas);
        old    = 48'(i_old);
        lvl    = 48'(i_cfg.level);
        d      = meas - old;
        amag   = $signed(f_abs(meas));
        alvl   = f_abs(lvl);
        hys    = i_active ? $signed(f_frac(alvl, 32'(i_cfg.hyst))) : 48'sh0;
        thr_hi = lvl - hys;
        thr_lo = lvl + hys;
        // Percent modes scale the level by the old sample, measval modes take it as is
        pick   = (i_cfg.mode == M_DPCT || i_cfg.mode == M_DPCT_ABS) ?
                 f_frac(f_abs(old), alvl[31:0]) : alvl;
        rel    = $signed(pick) - (i_active ? $signed(f_frac(pick, 32'(i_cfg.hyst))) : 48'sh0);
        case (i_cfg.mode)
            M_OVER:      o_cond = meas > thr_hi;
            M_OVER_ABS:  o_cond = amag > thr_hi;
            M_UNDER:     o_cond = meas < thr_lo && !(i_cfg.blim_en && meas < 48'(i_cfg.blim));
            M_UNDER_ABS: o_cond = amag < thr_lo && !(i_cfg.blim_en && amag < 48'(i_cfg.blim));
            M_DPCT:      o_cond = (lvl >= 0) ? d > rel : -d > rel;
            M_DPCT_ABS:  o_cond = $signed(f_abs(d)) > rel;
            M_DVAL:      o_cond = (lvl >= 0) ? d > rel : -d > rel;
            M_DVAL_ABS:  o_cond = $signed(f_abs(d)) > rel;
            default:     o_cond = 1'b0;
        endcase
    end

endmodule

// ===== hdl/pscmp_top.sv
// Contract
// - Over: value above level picks up
// - Over abs: magnitude above level picks up
// - Under: below level, blocking limit suppresses
// - Under abs: magnitude below level, limit suppresses
// - Signed percent change in 20 ms
// - Either-way percent change in 20 ms
// - Signed value change in 20 ms
// - Either-way value change in 20 ms
// - Per-level signed setting, hysteresis default 3%
// - Separate operate and release delays
// - Block input sampled each program cycle start
// - Pick-up unblocked raises start, runs timing
// - Pick-up blocked raises blocked, no timing
// - Block during start: drop start, release handling
// - Timestamped ON/OFF events with selection
// - Clearable start, trip, blocked counters
// - Twelve-record circular log overwrites oldest
// - Record: time, identity, magnitude, ratio, remaining, group
// - Hysteresis relative to pick-up setting
module pscmp_top #(
    parameter int unsigned MS_CYCLES = pscmp_pkg::MS_CYC
) (
    // Clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_nrst,
    // Measurement and block input
    input  wire logic signed [31:0]       i_meas,
    input  wire logic                     i_block,
    input  wire logic [2:0]               i_set_group,
    // Stage outputs
    output logic                          o_start,
    output logic                          o_trip,
    output logic                          o_blocked,
    output logic [5:0]                    o_evt,
    output logic [31:0]                   o_evt_stamp,
    // AXI4-Lite write
    input  wire logic [7:0]               i_s_awaddr,
    input  wire logic                     i_s_awvalid,
    output logic                          o_s_awready,
    input  wire logic [31:0]              i_s_wdata,
    input  wire logic [3:0]               i_s_wstrb,
    input  wire logic                     i_s_wvalid,
    output logic                          o_s_wready,
    output logic [1:0]                    o_s_bresp,
    output logic                          o_s_bvalid,
    input  wire logic                     i_s_bready,
    // AXI4-Lite read
    input  wire logic [7:0]               i_s_araddr,
    input  wire logic                     i_s_arvalid,
    output logic                          o_s_arready,
    output logic [31:0]                   o_s_rdata,
    output logic [1:0]                    o_s_rresp,
    output logic                          o_s_rvalid,
    input  wire logic                     i_s_rready
);
    import pscmp_pkg::*;

    typedef struct packed {
        logic [31:0]                       ms_cnt;
        logic [7:0]                        prog_cnt;
        logic [31:0]                       stamp;
        pscmp_cfg_t                        cfg;
        logic [31:0]                       op_dly;
        logic [31:0]                       rel_dly;
        logic [5:0]                        evt_sel;
        logic [DELTA_TAPS-1:0][31:0]       hist;
        logic                              cond;
        logic                              blk;
        pscmp_state_t                      st;
        logic [31:0]                       op_cnt;
        logic [31:0]                       rel_cnt;
        logic                              rel_on;
        logic                              start;
        logic                              trip;
        logic                              blocked;
        logic [31:0]                       cnt_start;
        logic [31:0]                       cnt_trip;
        logic [31:0]                       cnt_blk;
        pscmp_rec_t [LOG_DEPTH-1:0]        log;
        logic [3:0]                        wr_ptr;
        logic [3:0]                        log_num;
        logic [3:0]                        log_sel;
        logic [5:0]                        evt;
        logic [31:0]                       evt_stamp;
        logic                              aw_got;
        logic                              w_got;
        logic [7:0]                        awaddr;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic                              awrdy;
        logic                              wrdy;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              arrdy;
        logic                              rvalid;
        logic [1:0]                        rresp;
        logic [31:0]                       rdata;
    } pscmp_state_reg_t;

    pscmp_state_reg_t r_reg;
    pscmp_state_reg_t r_next;

    logic       cmp_cond;
    logic       ms_tick;
    logic       prog_tick;
    logic [5:0] ev;
    logic [2:0] clr;
    logic [4:0] li;
    pscmp_rec_t rec;

    // Comparator sees the sample taken 20 ms before the present one
    pscmp_cmp pscmp_cmp_i (
        .i_cfg    (r_reg.cfg),
        .i_meas   (i_meas),
        .i_old    ($signed(r_reg.hist[DELTA_TAPS-1])),
        .i_active (r_reg.cond),
        .o_cond   (cmp_cond)
    );

    // Next-state logic for the whole block
    always_comb begin
        r_next    = r_reg;
        r_next.evt = 6'h00;
        clr       = 3'h0;
        ev        = 6'h00;
        li        = 5'h00;
        rec       = '0;

        // Millisecond time base and program cycle tick
        ms_tick   = (r_reg.ms_cnt == 32'(MS_CYCLES - 1));
        prog_tick = ms_tick && (r_reg.prog_cnt == 8'(PROG_MS - 1));
        r_next.ms_cnt = ms_tick ? 32'h0 : r_reg.ms_cnt + 32'h1;
        if (ms_tick) begin
            r_next.stamp    = r_reg.stamp + 32'h1;
            r_next.prog_cnt = prog_tick ? 8'h00 : r_reg.prog_cnt + 8'h01;
        end

        // Timers run on the ms base; release handling freezes the operate timer
        if (ms_tick && r_reg.rel_on) begin
            if (r_reg.rel_cnt != 32'h0) begin
                r_next.rel_cnt = r_reg.rel_cnt - 32'h1;
            end else begin
                r_next.rel_on = 1'b0;
                r_next.op_cnt = 32'h0;
                if (r_reg.st == S_START) begin
                    r_next.st = S_IDLE;
                end
            end
        end
        if (ms_tick && r_reg.st == S_START && !r_reg.rel_on) begin
            if (r_reg.op_cnt <= 32'h1) begin
                r_next.op_cnt = 32'h0;
                r_next.st     = S_TRIP;
            end else begin
                r_next.op_cnt = r_reg.op_cnt - 32'h1;
            end
        end

        // Block input and comparison are taken once per program cycle
        if (prog_tick) begin
            r_next.blk  = i_block;
            r_next.cond = cmp_cond;
            r_next.hist = {r_reg.hist[DELTA_TAPS-2:0], i_meas};
            case (r_reg.st)
                S_IDLE: begin
                    if (cmp_cond && i_block) begin
                        r_next.st = S_BLOCKED;
                    end else if (cmp_cond) begin
                        r_next.st     = S_START;
                        r_next.rel_on = 1'b0;
                        // A re-pickup inside the release delay resumes the timer
                        if (!r_reg.rel_on || r_reg.rel_cnt == 32'h0) begin
                            r_next.op_cnt = r_reg.op_dly;
                        end
                    end
                end
                S_START: begin
                    if (i_block) begin
                        r_next.st = S_BLOCKED;
                        if (!r_reg.rel_on) begin
                            r_next.rel_on  = 1'b1;
                            r_next.rel_cnt = r_reg.rel_dly;
                        end
                    end else if (cmp_cond) begin
                        r_next.rel_on = 1'b0;
                    end else if (!r_reg.rel_on) begin
                        r_next.rel_on  = 1'b1;
                        r_next.rel_cnt = r_reg.rel_dly;
                    end
                end
                S_TRIP: begin
                    if (i_block) begin
                        r_next.st = S_BLOCKED;
                    end else if (!cmp_cond) begin
                        r_next.st     = S_IDLE;
                        r_next.op_cnt = 32'h0;
                    end
                end
                S_BLOCKED: begin
                    if (!i_block || !cmp_cond) begin
                        r_next.st = S_IDLE;
                    end
                end
                default: r_next.st = S_IDLE;
            endcase
        end

        // Outputs follow the state
        r_next.start   = (r_next.st == S_START) || (r_next.st == S_TRIP);
        r_next.trip    = (r_next.st == S_TRIP);
        r_next.blocked = (r_next.st == S_BLOCKED);

        // ON and OFF edges, filtered by the event selection
        ev[0] = r_next.start & ~r_reg.start;
        ev[1] = ~r_next.start & r_reg.start;
        ev[2] = r_next.trip & ~r_reg.trip;
        ev[3] = ~r_next.trip & r_reg.trip;
        ev[4] = r_next.blocked & ~r_reg.blocked;
        ev[5] = ~r_next.blocked & r_reg.blocked;
        r_next.evt       = ev & r_reg.evt_sel;
        r_next.evt_stamp = r_reg.stamp;

        // One record per ON event; trip outranks start when both rise together
        if (ev[0] || ev[2] || ev[4]) begin
            rec.stamp  = r_reg.stamp;
            rec.id     = ev[2] ? ID_TRIP : (ev[0] ? ID_START : ID_BLOCK);
            rec.mag    = i_meas;
            rec.ratio  = (r_reg.cfg.level == 32'sh0) ? 32'sh0 :
                         32'((48'(i_meas) <<< RATIO_SH) / 48'(r_reg.cfg.level));
            rec.remain = r_next.op_cnt;
            rec.group  = i_set_group;
            r_next.log[r_reg.wr_ptr] = rec;
            r_next.wr_ptr  = (r_reg.wr_ptr == 4'(LOG_DEPTH - 1)) ? 4'h0 : r_reg.wr_ptr + 4'h1;
            r_next.log_num = (r_reg.log_num == 4'(LOG_DEPTH)) ? r_reg.log_num : r_reg.log_num + 4'h1;
        end

        // Write channel: address and data may arrive in either order
        if (r_reg.awrdy && i_s_awvalid) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = i_s_awaddr;
        end
        if (r_reg.wrdy && i_s_wvalid) begin
            r_next.w_got = 1'b1;
            r_next.wdata = i_s_wdata;
            r_next.wstrb = i_s_wstrb;
        end
        if (r_reg.bvalid && i_s_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_next.aw_got && r_next.w_got && !r_reg.bvalid) begin
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = RESP_OKAY;
            case ({r_next.awaddr[7:2], 2'b00})
                A_CTRL:      clr = r_next.wdata[2:0] & {3{r_next.wstrb[0]}};
                A_MODE: begin
                    if (r_next.wstrb[0]) begin
                        r_next.cfg.mode    = pscmp_mode_t'(r_next.wdata[2:0]);
                        r_next.cfg.blim_en = r_next.wdata[F_BLIM_EN];
                    end
                end
                A_LEVEL:     r_next.cfg.level = $signed(f_merge(r_reg.cfg.level, r_next.wdata, r_next.wstrb));
                A_HYST:      r_next.cfg.hyst = 16'(f_merge(32'(r_reg.cfg.hyst), r_next.wdata, r_next.wstrb));
                A_BLIM:      r_next.cfg.blim = $signed(f_merge(r_reg.cfg.blim, r_next.wdata, r_next.wstrb));
                A_OP_DLY:    r_next.op_dly = f_merge(r_reg.op_dly, r_next.wdata, r_next.wstrb);
                A_REL_DLY:   r_next.rel_dly = f_merge(r_reg.rel_dly, r_next.wdata, r_next.wstrb);
                A_EVT_SEL:   r_next.evt_sel = 6'(f_merge(32'(r_reg.evt_sel), r_next.wdata, r_next.wstrb));
                A_LOG_SEL:   r_next.log_sel = 4'(f_merge(32'(r_reg.log_sel), r_next.wdata, r_next.wstrb));
                A_STATUS, A_CNT_START, A_CNT_TRIP, A_CNT_BLK,
                A_LOG_TIME, A_LOG_ID, A_LOG_MAG, A_LOG_RATIO, A_LOG_REM: ;
                default:     r_next.bresp = RESP_SLVERR;
            endcase
        end
        r_next.awrdy = !r_next.aw_got && !r_next.bvalid;
        r_next.wrdy  = !r_next.w_got && !r_next.bvalid;

        // Counters: an increment in the clearing cycle still counts
        r_next.cnt_start = (clr[0] ? 32'h0 : r_reg.cnt_start) + 32'(ev[0]);
        r_next.cnt_trip  = (clr[1] ? 32'h0 : r_reg.cnt_trip) + 32'(ev[2]);
        r_next.cnt_blk   = (clr[2] ? 32'h0 : r_reg.cnt_blk) + 32'(ev[4]);

        // Log index: selection 0 is the newest record
        li = 5'(r_reg.wr_ptr) + 5'(LOG_DEPTH - 1) - 5'(r_reg.log_sel);
        if (li >= 5'(LOG_DEPTH)) begin
            li = li - 5'(LOG_DEPTH);
        end

        // Read channel
        if (r_reg.rvalid && i_s_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (r_reg.arrdy && i_s_arvalid) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = RESP_OKAY;
            case ({i_s_araddr[7:2], 2'b00})
                A_CTRL:      r_next.rdata = 32'h0;
                A_MODE:      r_next.rdata = {27'h0, r_reg.cfg.blim_en, 1'b0, r_reg.cfg.mode};
                A_LEVEL:     r_next.rdata = r_reg.cfg.level;
                A_HYST:      r_next.rdata = 32'(r_reg.cfg.hyst);
                A_BLIM:      r_next.rdata = r_reg.cfg.blim;
                A_OP_DLY:    r_next.rdata = r_reg.op_dly;
                A_REL_DLY:   r_next.rdata = r_reg.rel_dly;
                A_EVT_SEL:   r_next.rdata = 32'(r_reg.evt_sel);
                A_STATUS:    r_next.rdata = {16'h0, r_reg.log_num, 6'h00, r_reg.rel_on, r_reg.blk,
                                             r_reg.cond, r_reg.blocked, r_reg.trip, r_reg.start};
                A_CNT_START: r_next.rdata = r_reg.cnt_start;
                A_CNT_TRIP:  r_next.rdata = r_reg.cnt_trip;
                A_CNT_BLK:   r_next.rdata = r_reg.cnt_blk;
                A_LOG_SEL:   r_next.rdata = 32'(r_reg.log_sel);
                A_LOG_TIME:  r_next.rdata = r_reg.log[li[3:0]].stamp;
                A_LOG_ID:    r_next.rdata = {21'h0, r_reg.log[li[3:0]].group, 6'h00, r_reg.log[li[3:0]].id};
                A_LOG_MAG:   r_next.rdata = r_reg.log[li[3:0]].mag;
                A_LOG_RATIO: r_next.rdata = r_reg.log[li[3:0]].ratio;
                A_LOG_REM:   r_next.rdata = r_reg.log[li[3:0]].remain;
                default: begin
                    r_next.rdata = 32'h0;
                    r_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        r_next.arrdy = !r_next.rvalid;
    end

    // State register; settings come up at their documented defaults
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_reg           <= '0;
            r_reg.cfg.mode  <= M_OVER;
            r_reg.cfg.level <= LEVEL_RST;
            r_reg.cfg.hyst  <= HYST_RST;
            r_reg.op_dly    <= OP_DLY_RST;
            r_reg.rel_dly   <= REL_DLY_RST;
            r_reg.evt_sel   <= EVT_SEL_RST;
            r_reg.st        <= S_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // Ports straight from the register
    assign o_start     = r_reg.start;
    assign o_trip      = r_reg.trip;
    assign o_blocked   = r_reg.blocked;
    assign o_evt       = r_reg.evt;
    assign o_evt_stamp = r_reg.evt_stamp;
    assign o_s_awready = r_reg.awrdy;
    assign o_s_wready  = r_reg.wrdy;
    assign o_s_bvalid  = r_reg.bvalid;
    assign o_s_bresp   = r_reg.bresp;
    assign o_s_arready = r_reg.arrdy;
    assign o_s_rvalid  = r_reg.rvalid;
    assign o_s_rresp   = r_reg.rresp;
    assign o_s_rdata   = r_reg.rdata;

endmodule

// ===== dv/pscmp_sva.sv
module pscmp_sva (
    // Clock, reset and stage outputs
    input wire logic        i_ref_clk, i_nrst, o_start, o_trip, o_blocked,
    input wire logic [5:0]  o_evt,
    // Register bus handshakes
    input wire logic        i_s_awvalid, o_s_awready, i_s_wvalid, o_s_wready, i_s_bready, o_s_bvalid,
    input wire logic        i_s_arvalid, o_s_arready, i_s_rready, o_s_rvalid,
    input wire logic [1:0]  o_s_bresp,
    input wire logic [31:0] o_s_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Address and data taken at the same edge
    sequence s_wr_both; i_s_awvalid && o_s_awready && i_s_wvalid && o_s_wready; endsequence
    // Answer offered but not yet accepted
    sequence s_b_wait; o_s_bvalid && !i_s_bready; endsequence
    a_trip_has_start: assert property (o_trip |-> o_start) else $error("trip without start");
    a_start_not_blk: assert property (!(o_start && o_blocked)) else $error("start with blocked");
    a_start_on_evt: assert property (o_evt[0] |-> o_start && !$past(o_start)) else $error("start event");
    a_trip_on_evt: assert property (o_evt[2] |-> o_trip && !$past(o_trip)) else $error("trip event");
    a_blk_on_evt: assert property (o_evt[4] |-> o_blocked && !$past(o_blocked)) else $error("block event");
    a_evt_one_cycle: assert property (o_evt != 6'h00 |=> o_evt == 6'h00) else $error("event not a pulse");
    a_wr_answer: assert property (s_wr_both |=> o_s_bvalid) else $error("write answer late");
    a_b_holds: assert property (s_b_wait |=> o_s_bvalid && $stable(o_s_bresp)) else $error("bresp dropped");
    a_rd_answer: assert property (i_s_arvalid && o_s_arready |=> o_s_rvalid) else $error("read answer late");
    a_r_holds: assert property (o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata))
        else $error("rdata dropped");
endmodule

bind pscmp_top pscmp_sva pscmp_sva_i (.i_ref_clk, .i_nrst, .o_start, .o_trip, .o_blocked, .o_evt,
    .i_s_awvalid, .o_s_awready, .i_s_wvalid, .o_s_wready, .i_s_bready, .o_s_bvalid, .i_s_arvalid,
    .o_s_arready, .i_s_rready, .o_s_rvalid, .o_s_bresp, .o_s_rdata);

// ===== dv/tb_pscmp_top.sv
module tb_pscmp_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pscmp_pkg::*;
    logic i_ref_clk = 0, i_nrst = 0, i_block = 0, i_s_awvalid = 0, i_s_wvalid = 0, i_s_bready = 0;
    logic i_s_arvalid = 0, i_s_rready = 0, o_start, o_trip, o_blocked, o_s_awready, o_s_wready;
    logic o_s_bvalid, o_s_arready, o_s_rvalid;
    logic signed [31:0] i_meas = 0;
    logic [7:0]  i_s_awaddr = 0, i_s_araddr = 0;
    logic [31:0] i_s_wdata = 0, o_evt_stamp, o_s_rdata, rd;
    logic [5:0]  o_evt;
    logic [1:0]  o_s_bresp, o_s_rresp, rs;
    int          failures = 0, comparisons = 0;
    // Ten clocks per ms keeps the delays short
    pscmp_top #(.MS_CYCLES(10)) pscmp_top_i (.i_ref_clk, .i_nrst, .i_meas, .i_block, .i_set_group(3'h2),
        .o_start, .o_trip, .o_blocked, .o_evt, .o_evt_stamp, .i_s_awaddr, .i_s_awvalid, .o_s_awready,
        .i_s_wdata, .i_s_wstrb(4'hf), .i_s_wvalid, .o_s_wready, .o_s_bresp, .o_s_bvalid, .i_s_bready,
        .i_s_araddr, .i_s_arvalid, .o_s_arready, .o_s_rdata, .o_s_rresp, .o_s_rvalid, .i_s_rready);
    always #50 i_ref_clk = ~i_ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Handshakes judged at the falling edge, released right after the rising edge that took them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ka, kw, kb;
        @(posedge i_ref_clk);
        i_s_awaddr <= a;
        i_s_wdata <= d;
        i_s_awvalid <= 1'b1;
        i_s_wvalid <= 1'b1;
        i_s_bready <= 1'b1;
        do begin
            @(negedge i_ref_clk);
            ka = i_s_awvalid && o_s_awready;
            kw = i_s_wvalid && o_s_wready;
            kb = o_s_bvalid;
            @(posedge i_ref_clk);
            if (ka) i_s_awvalid <= 1'b0;
            if (kw) i_s_wvalid <= 1'b0;
            if (kb) i_s_bready <= 1'b0;
        end while (kb !== 1'b1);
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ka, k;
        @(posedge i_ref_clk);
        i_s_araddr <= a;
        i_s_arvalid <= 1'b1;
        i_s_rready <= 1'b1;
        do begin
            @(negedge i_ref_clk);
            ka = i_s_arvalid && o_s_arready;
            k = o_s_rvalid;
            rd = o_s_rdata;
            rs = o_s_rresp;
            @(posedge i_ref_clk);
            if (ka) i_s_arvalid <= 1'b0;
            if (k) i_s_rready <= 1'b0;
        end while (k !== 1'b1);
    endtask
    task automatic t_regs;
        rdr(A_LEVEL); chk("level", 32'h1, rd);
        rdr(A_HYST); chk("hyst", 32'h12c, rd);
        rdr(A_OP_DLY); chk("op_dly", 32'h28, rd);
        rdr(A_REL_DLY); chk("rel_dly", 32'h3c, rd);
        rdr(A_EVT_SEL); chk("evt_sel", 32'h3f, rd);
        rdr(8'h80); chk("unmapped", 32'h2, 32'(rs));
        $display("test regs done");
    endtask
    // Trip needs 400 clocks of start; 97 is the release point with 3 percent hysteresis
    task automatic t_over;
        wr(A_LEVEL, 32'h64);
        @(posedge i_ref_clk) i_meas <= 32'sd200;
        cyc(60); chk("start", 32'h1, 32'(o_start));
        cyc(300); chk("trip early", 32'h0, 32'(o_trip));
        cyc(150); chk("trip", 32'h1, 32'(o_trip));
        @(posedge i_ref_clk) i_meas <= 32'sd98;
        cyc(100); chk("trip held", 32'h1, 32'(o_trip));
        @(posedge i_ref_clk) i_meas <= 32'sd0;
        cyc(800); chk("start off", 32'h0, 32'(o_start));
        rdr(A_CNT_TRIP); chk("trip count", 32'h1, rd);
        $display("test over done");
    endtask
    task automatic t_block;
        @(posedge i_ref_clk) i_meas <= 32'sd200;
        cyc(60); chk("start", 32'h1, 32'(o_start));
        @(posedge i_ref_clk) i_block <= 1'b1;
        cyc(60); chk("blocked", 32'h1, 32'(o_blocked));
        rdr(A_CNT_START); chk("start count", 32'h2, rd);
        wr(A_CTRL, 32'h7);
        rdr(A_CNT_START); chk("start cleared", 32'h0, rd);
        @(posedge i_ref_clk) i_block <= 1'b0;
        $display("test block done");
    endtask
    // Under mode with a blocking limit of 60 below a level of 100
    task automatic t_under;
        @(posedge i_ref_clk) i_meas <= 32'sd50;
        cyc(800);
        wr(A_BLIM, 32'h3c);
        wr(A_MODE, 32'h12);
        cyc(60); chk("limited", 32'h0, 32'(o_start));
        @(posedge i_ref_clk) i_meas <= 32'sd80;
        cyc(60); chk("under", 32'h1, 32'(o_start));
        rdr(A_LOG_ID); chk("log id", 32'h201, rd);
        rdr(A_LOG_MAG); chk("log mag", 32'h50, rd);
        $display("test under done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence after a reset of 12 clocks
    initial begin
        cyc(12);
        i_nrst <= 1'b1;
        cyc(2);
        t_regs;
        t_over;
        t_block;
        t_under;
        report_and_stop;
    end
    // Watchdog well beyond the roughly 2500 clocks the tests need
    initial begin
        cyc(9000);
        failures++;
        report_and_stop;
    end
endmodule
